// *** design/mic_pkg.sv ***
// Constants and carrier types for the interrupt controller
package mic_pkg;
   // Data memory addresses of the control registers
   localparam logic [7:0] ADDR_PRIMARY = 8'h0B;
   localparam logic [7:0] ADDR_SECONDARY = 8'h1E;
   localparam logic [7:0] ADDR_GROUP = 8'h2F;
   // Field positions, primary register
   localparam int BIT_GIE = 0;
   localparam int BIT_EN_PIN = 1;
   localparam int BIT_EN_T0 = 2;
   localparam int BIT_EN_T1 = 3;
   localparam int BIT_PIN_F = 4;
   localparam int BIT_T0_F = 5;
   localparam int BIT_T1_F = 6;
   // Field positions, secondary register
   localparam int BIT_EN_UART = 0;
   localparam int BIT_EN_I2C = 1;
   localparam int BIT_EN_GRP = 2;
   localparam int BIT_UART_F = 4;
   localparam int BIT_I2C_F = 5;
   localparam int BIT_GRP_F = 6;
   // Field positions, group register
   localparam int BIT_EN_T2 = 0;
   localparam int BIT_EN_TB = 1;
   localparam int BIT_EN_RTC = 2;
   localparam int BIT_T2_F = 4;
   localparam int BIT_TB_F = 5;
   localparam int BIT_RTC_F = 6;
   // Writable bits; the rest read as zero
   localparam logic [7:0] MASK_PRIMARY = 8'h7F;
   localparam logic [7:0] MASK_OTHER = 8'h77;
   localparam logic [7:0] RESET_REG = 8'h00;
   localparam logic [5:0] RESET_FLAGS = 6'h00;
   localparam logic [2:0] RESET_GFLAGS = 3'h0;
   // Vectors, priority order from index 0
   localparam logic [7:0] VEC_PIN = 8'h04;
   localparam logic [7:0] VEC_T0 = 8'h08;
   localparam logic [7:0] VEC_T1 = 8'h0C;
   localparam logic [7:0] VEC_UART = 8'h10;
   localparam logic [7:0] VEC_I2C = 8'h14;
   localparam logic [7:0] VEC_GRP = 8'h18;
   localparam logic [2:0] SYNC_IDLE = 3'h7;

   // Data memory access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } mic_mem_t;

   // Same-domain one-cycle events from peripherals
   typedef struct packed {
      logic tmr0_ovf;
      logic tmr1_ovf;
      logic [3:0] uart_status;
      logic slave_addr_match;
      logic i2c_byte_done;
      logic tmr2_ovf;
      logic tb_timeout;
      logic rtc_timeout;
   } mic_src_t;

   // Sequencer status from the core
   typedef struct packed {
      logic boundary;
      logic stack_full;
      logic return_from_irq;
      logic plain_return;
      logic halted;
   } mic_core_t;
endpackage

// *** design/mic_top.sv ***
// Interrupt controller: flags, enables, priority and vector call
// Functional notes
// - Six request groups: pin, timer0, timer1, UART, I2C, combined group.
// - Enables and flags live in registers at 0BH, 1EH and 2FH.
// - Any acknowledge clears the global enable bit.
// - Requests still set their flags while servicing is blocked.
// - No acknowledge while the return stack is full.
// - Every enabled pending source can wake the device from halt.
// - Acknowledge pushes only the PC and branches to the vector.
// - Falling edge on the pin sets primary bit 4.
// - Pin request calls 04H, clears its flag and global enable.
// - Timer0 overflow sets bit 5, calls 08H, clears flag and enable.
// - Timer1 overflow sets bit 6, calls 0CH, same clearing.
// - UART status sets secondary bit 4; calls 010H, clears flag, enable.
// - Address match or byte done sets bit 5; calls 014H, clears.
// - Group flag set when an enabled timer2, RTC or time base flag sets.
// - Enabled group request calls 018H, clears group flag and enable.
// - The three group source flags are cleared only by software.
// - Fixed priority: pin, timer0, timer1, UART, I2C, group last.
// - Interrupt return sets global enable; plain return leaves it.
// - Flags stay set until serviced or cleared by software.
// - Primary bit 0 is the global enable, 1 enables.
module mic_top
   import mic_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic irq_pin_n,
   input wire mic_pkg::mic_mem_t mem,
   input wire mic_pkg::mic_src_t src,
   input wire mic_pkg::mic_core_t core,
   output logic [7:0] rdata_r,
   output logic call_r,
   output logic [7:0] vector_r,
   output logic wake_r
);
   import mic_pkg::*;

   logic [2:0] pin_sync_r;
   logic pin_fall;
   logic global_irq_enable_r;
   logic [5:0] en_r;
   logic [5:0] flag_r;
   logic [2:0] grp_en_r;
   logic [2:0] grp_flag_r;
   logic [5:0] set_ev;
   logic [5:0] pend;
   logic [5:0] grant_nxt;
   logic ack_go;
   logic wr_pri;
   logic wr_sec;
   logic wr_grp;
   logic [2:0] grp_set;
   logic [7:0] rd_nxt;
   logic [7:0] vec_nxt;

   // Pin passes three flops; only the later two stages feed the edge detect
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pin_sync_r <= SYNC_IDLE;
      else
         pin_sync_r <= {pin_sync_r[1:0], irq_pin_n};
   end

   assign pin_fall = pin_sync_r[2] & ~pin_sync_r[1];

   // Register decode at the documented data memory addresses
   assign wr_pri = mem.wr && mem.addr == ADDR_PRIMARY;
   assign wr_sec = mem.wr && mem.addr == ADDR_SECONDARY;
   assign wr_grp = mem.wr && mem.addr == ADDR_GROUP;

   // Group source events; each always sets its own flag, the group flag only when its own enable is on
   assign grp_set = {src.rtc_timeout, src.tb_timeout, src.tmr2_ovf};

   // Hardware set events for the six main flags
   always_comb
   begin
      set_ev[0] = pin_fall;
      set_ev[1] = src.tmr0_ovf;
      set_ev[2] = src.tmr1_ovf;
      set_ev[3] = |src.uart_status;
      set_ev[4] = src.slave_addr_match | src.i2c_byte_done;
      set_ev[5] = |(grp_set & grp_en_r);
   end

   // Pending and enabled, index 0 is the highest priority
   assign pend = flag_r & en_r;
   assign ack_go = core.boundary && global_irq_enable_r
      && !core.stack_full && (|pend);

   // One-hot winner: lowest set index wins
   always_comb
   begin
      grant_nxt = '0;
      vec_nxt = vector_r;
      if (pend[0])
      begin
         grant_nxt[0] = 1'b1;
         vec_nxt = VEC_PIN;
      end
      else if (pend[1])
      begin
         grant_nxt[1] = 1'b1;
         vec_nxt = VEC_T0;
      end
      else if (pend[2])
      begin
         grant_nxt[2] = 1'b1;
         vec_nxt = VEC_T1;
      end
      else if (pend[3])
      begin
         grant_nxt[3] = 1'b1;
         vec_nxt = VEC_UART;
      end
      else if (pend[4])
      begin
         grant_nxt[4] = 1'b1;
         vec_nxt = VEC_I2C;
      end
      else if (pend[5])
      begin
         grant_nxt[5] = 1'b1;
         vec_nxt = VEC_GRP;
      end
   end

   // Global enable: acknowledge clears, interrupt return sets
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         global_irq_enable_r <= 1'b0;
      else if (ack_go)
         global_irq_enable_r <= 1'b0;
      else if (core.return_from_irq)
         global_irq_enable_r <= 1'b1;
      else if (wr_pri)
         global_irq_enable_r <= mem.wdata[BIT_GIE];
   end

   // Individual enables, software only
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         en_r <= RESET_FLAGS;
         grp_en_r <= RESET_GFLAGS;
      end
      else
      begin
         if (wr_pri)
         begin
            en_r[0] <= mem.wdata[BIT_EN_PIN];
            en_r[1] <= mem.wdata[BIT_EN_T0];
            en_r[2] <= mem.wdata[BIT_EN_T1];
         end
         if (wr_sec)
         begin
            en_r[3] <= mem.wdata[BIT_EN_UART];
            en_r[4] <= mem.wdata[BIT_EN_I2C];
            en_r[5] <= mem.wdata[BIT_EN_GRP];
         end
         if (wr_grp)
         begin
            grp_en_r[0] <= mem.wdata[BIT_EN_T2];
            grp_en_r[1] <= mem.wdata[BIT_EN_TB];
            grp_en_r[2] <= mem.wdata[BIT_EN_RTC];
         end
      end
   end

   // Main flags; a hardware set beats both software and ack clears,
   // so an event landing on the clearing cycle stays pending
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         flag_r <= RESET_FLAGS;
      else
      begin
         for (int i = 0; i < 6; i++)
         begin
            if (set_ev[i])
               flag_r[i] <= 1'b1;
            else if (ack_go && grant_nxt[i])
               flag_r[i] <= 1'b0;
            else if (i < 3 && wr_pri)
               flag_r[i] <= mem.wdata[BIT_PIN_F + i];
            else if (i >= 3 && wr_sec)
               flag_r[i] <= mem.wdata[BIT_UART_F + i - 3];
         end
      end
   end

   // Group source flags: never cleared by acknowledge or by reading
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         grp_flag_r <= RESET_GFLAGS;
      else
      begin
         for (int j = 0; j < 3; j++)
         begin
            if (grp_set[j])
               grp_flag_r[j] <= 1'b1;
            else if (wr_grp)
               grp_flag_r[j] <= mem.wdata[BIT_T2_F + j];
         end
      end
   end

   // Call pulse and vector; the core pushes only the PC on it
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         call_r <= 1'b0;
         vector_r <= RESET_REG;
      end
      else
      begin
         call_r <= ack_go;
         vector_r <= ack_go ? vec_nxt : vector_r;
      end
   end

   // Wake needs no global enable, so a masked core still leaves halt
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wake_r <= 1'b0;
      else
         wake_r <= core.halted && (|pend);
   end

   // Read mux; unused bits and other addresses read zero
   always_comb
   begin
      rd_nxt = RESET_REG;
      case (mem.addr)
         ADDR_PRIMARY:
            rd_nxt = {1'b0, flag_r[2:0], en_r[2:0], global_irq_enable_r};
         ADDR_SECONDARY:
            rd_nxt = {1'b0, flag_r[5:3], 1'b0, en_r[5:3]};
         ADDR_GROUP:
            rd_nxt = {1'b0, grp_flag_r, 1'b0, grp_en_r};
         default:
            rd_nxt = RESET_REG;
      endcase
   end

   // Read data stands one cycle per strobed cycle, then drops back to zero
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata_r <= RESET_REG;
      else
         rdata_r <= mem.rd ? (rd_nxt & (mem.addr == ADDR_PRIMARY
            ? MASK_PRIMARY : MASK_OTHER)) : RESET_REG;
   end

   // Checks
   sequence s_grant_ok;
      core.boundary && global_irq_enable_r && !core.stack_full;
   endsequence

   sequence s_call_out(logic [7:0] v);
      call_r && vector_r == v && !global_irq_enable_r;
   endsequence

   a_ack_clears_gie: assert property (@(posedge clock)
      disable iff (rst) call_r |-> !global_irq_enable_r)
      else $error("global enable still set at call");

   a_full_blocks_ack: assert property (@(posedge clock)
      disable iff (rst) core.stack_full |=> !call_r)
      else $error("call issued with stack full");

   a_pin_vector: assert property (@(posedge clock)
      disable iff (rst) s_grant_ok ##0 pend[0] |=> s_call_out(VEC_PIN))
      else $error("pin request not called at its vector");

   a_timer0_prio: assert property (@(posedge clock)
      disable iff (rst)
      s_grant_ok ##0 (pend[1:0] == 2'h2) |=> s_call_out(VEC_T0))
      else $error("timer0 vector or priority wrong");

   a_timer1_vector: assert property (@(posedge clock)
      disable iff (rst)
      s_grant_ok ##0 (pend[2:0] == 3'h4) |=> s_call_out(VEC_T1))
      else $error("timer1 vector or priority wrong");

   a_uart_vector: assert property (@(posedge clock)
      disable iff (rst)
      s_grant_ok ##0 (pend[3:0] == 4'h8) |=> s_call_out(VEC_UART))
      else $error("serial vector or priority wrong");

   a_i2c_vector: assert property (@(posedge clock)
      disable iff (rst)
      s_grant_ok ##0 (pend[4:0] == 5'h10) |=> s_call_out(VEC_I2C))
      else $error("two wire vector or priority wrong");

   a_group_last: assert property (@(posedge clock)
      disable iff (rst)
      s_grant_ok ##0 (pend == 6'h20) |=> s_call_out(VEC_GRP))
      else $error("group request not called at its vector");

   a_ack_clears_flag: assert property (@(posedge clock)
      disable iff (rst)
      s_grant_ok ##0 (pend == 6'h02 && !src.tmr0_ovf) |=> !flag_r[1])
      else $error("timer0 flag kept after its call");

   a_pin_edge_sets: assert property (@(posedge clock)
      disable iff (rst) pin_fall |=> flag_r[0])
      else $error("pin edge did not set its flag");

   a_blocked_records: assert property (@(posedge clock)
      disable iff (rst)
      !global_irq_enable_r && src.tmr0_ovf |=> flag_r[1])
      else $error("masked overflow not recorded");

   a_group_sets_main: assert property (@(posedge clock)
      disable iff (rst) |(grp_set & grp_en_r) |=> flag_r[5])
      else $error("group event did not raise the group flag");

   a_flag_holds: assert property (@(posedge clock)
      disable iff (rst)
      flag_r[1] && !(ack_go && grant_nxt[1]) && !wr_pri |=> flag_r[1])
      else $error("timer0 flag dropped without service or write");

   a_gie_write: assert property (@(posedge clock)
      disable iff (rst) wr_pri && !ack_go && !core.return_from_irq
      |=> global_irq_enable_r == $past(mem.wdata[BIT_GIE]))
      else $error("global enable did not follow the write");

   a_masked_no_call: assert property (@(posedge clock)
      disable iff (rst) !global_irq_enable_r |=> !call_r)
      else $error("call issued with global enable clear");

   a_return_from_irq_sets_gie: assert property (@(posedge clock)
      disable iff (rst)
      core.return_from_irq && !ack_go |=> global_irq_enable_r)
      else $error("interrupt return left global enable clear");

   a_ret_keeps_gie: assert property (@(posedge clock)
      disable iff (rst)
      core.plain_return && !core.return_from_irq && !ack_go && !wr_pri
      |=> $stable(global_irq_enable_r))
      else $error("plain return changed global enable");

   a_group_kept: assert property (@(posedge clock)
      disable iff (rst) grp_flag_r[0] && !wr_grp |=> grp_flag_r[0])
      else $error("timer2 flag cleared without a write");

   a_wake_on_pend: assert property (@(posedge clock)
      disable iff (rst) core.halted && (|pend) |=> wake_r)
      else $error("pending source did not wake");

   a_wake_needs_halt: assert property (@(posedge clock)
      disable iff (rst) !core.halted |=> !wake_r)
      else $error("wake raised while running");
endmodule

// *** tb/mic_core_model.sv ***
// Core sequencer stand-in: stack depth, returns, halt and boundary
module mic_core_model
   import mic_pkg::*;
#(
   parameter int DEPTH = 2
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic call_r,
   input wire logic ret_req,
   input wire logic plain_req,
   input wire logic halt_req,
   output mic_pkg::mic_core_t core
);
   timeunit 1ns;
   timeprecision 1ps;
   int depth_r;

   // Each call pushes, a return of either kind pops
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         depth_r <= 0;
      else
         depth_r <= depth_r + int'(call_r) - int'(ret_req | plain_req);
   end

   // Full stack only clears through a return; no boundary while halted
   assign core = {!halt_req, depth_r >= DEPTH, ret_req, plain_req,
      halt_req};
endmodule

// *** tb/mcu_interrupt_controller_tb.sv ***
// Self-checking bench for the interrupt controller
module mcu_interrupt_controller_tb
   import mic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0;
   logic rst = 1;
   logic irq_pin_n = 1;
   logic ret_req = 0;
   logic plain_req = 0;
   logic halt_req = 0;
   mic_mem_t mem = '0;
   mic_src_t src = '0;
   mic_core_t core;
   logic [7:0] rdata_r;
   logic [7:0] vector_r;
   logic call_r;
   logic wake_r;
   int n_fail = 0;
   int checks = 0;
   logic [7:0] vecs [6] = '{VEC_PIN, VEC_T0, VEC_T1, VEC_UART, VEC_I2C,
      VEC_GRP};

   mic_top u_dut (.clock(clock), .rst(rst), .irq_pin_n(irq_pin_n),
      .mem(mem), .src(src), .core(core), .rdata_r(rdata_r),
      .call_r(call_r), .vector_r(vector_r), .wake_r(wake_r));
   mic_core_model #(.DEPTH(2)) u_core (.clock(clock), .rst(rst),
      .call_r(call_r), .ret_req(ret_req), .plain_req(plain_req),
      .halt_req(halt_req), .core(core));

   task automatic give_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write strobe for one cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      mem <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clock);
      mem.wr <= 1'b0;
   endtask

   // Read data lands at the edge that samples the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      mem <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clock);
      mem.rd <= 1'b0;
      #1;
      chk(rdata_r, exp);
   endtask

   task automatic ret_pulse(input logic irq);
      @(posedge clock);
      if (irq)
         ret_req <= 1'b1;
      else
         plain_req <= 1'b1;
      @(posedge clock);
      ret_req <= 1'b0;
      plain_req <= 1'b0;
   endtask

   // Bounded wait; a missing call ends the run
   task automatic wait_call(input logic [7:0] exp);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clock);
         #1;
         if (call_r === 1'b1)
         begin
            chk(vector_r, exp);
            return;
         end
      end
      chk(8'hEE, exp);
      give_verdict();
   endtask

   task automatic no_call(input int n);
      logic seen;
      seen = 0;
      repeat (n)
      begin
         @(posedge clock);
         #1;
         if (call_r !== 1'b0)
            seen = 1;
      end
      chk({7'h00, seen}, 8'h00);
   endtask

   initial
   begin
      forever #5 clock = ~clock;
   end

   initial
   begin
      logic seen;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      // Reset values, reserved bits, unmapped place
      rd(ADDR_PRIMARY, 8'h00);
      rd(ADDR_SECONDARY, 8'h00);
      rd(ADDR_GROUP, 8'h00);
      wr(ADDR_PRIMARY, 8'hFE);
      rd(ADDR_PRIMARY, 8'h7E);
      wr(ADDR_SECONDARY, 8'hFF);
      rd(ADDR_SECONDARY, 8'h77);
      wr(ADDR_GROUP, 8'hFF);
      rd(ADDR_GROUP, 8'h77);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h00);
      // Enables on, flags clear, global enable off
      wr(ADDR_PRIMARY, 8'h0E);
      wr(ADDR_SECONDARY, 8'h07);
      wr(ADDR_GROUP, 8'h07);
      // Every source fires at once while masked
      @(posedge clock);
      src <= '1;
      irq_pin_n <= 1'b0;
      @(posedge clock);
      src <= '0;
      repeat (4) @(posedge clock);
      irq_pin_n <= 1'b1;
      rd(ADDR_PRIMARY, 8'h7E);
      rd(ADDR_SECONDARY, 8'h77);
      rd(ADDR_GROUP, 8'h77);
      wr(ADDR_PRIMARY, 8'h7F);
      // Calls come out in priority order, one per interrupt return
      for (int i = 0; i < 6; i++)
      begin
         wait_call(vecs[i]);
         if (i < 5)
            ret_pulse(1'b1);
      end
      rd(ADDR_PRIMARY, 8'h0E);
      rd(ADDR_SECONDARY, 8'h07);
      rd(ADDR_GROUP, 8'h77);
      ret_pulse(1'b0);
      rd(ADDR_PRIMARY, 8'h0E);
      // Nesting until the stack fills, then release by a return
      wr(ADDR_GROUP, 8'h07);
      wr(ADDR_PRIMARY, 8'h25);
      wait_call(VEC_T0);
      wr(ADDR_PRIMARY, 8'h25);
      wait_call(VEC_T0);
      wr(ADDR_PRIMARY, 8'h25);
      no_call(20);
      rd(ADDR_PRIMARY, 8'h25);
      ret_pulse(1'b0);
      wait_call(VEC_T0);
      rd(ADDR_PRIMARY, 8'h04);
      ret_pulse(1'b0);
      ret_pulse(1'b0);
      // Halted core woken by a pending source with global enable off
      @(posedge clock);
      halt_req <= 1'b1;
      wr(ADDR_SECONDARY, 8'h11);
      seen = 0;
      for (int i = 0; i < 10 && !seen; i++)
      begin
         @(posedge clock);
         #1;
         seen = (wake_r === 1'b1);
      end
      chk({7'h00, seen}, 8'h01);
      @(posedge clock);
      halt_req <= 1'b0;
      give_verdict();
   end
endmodule
